// ==== src/tws_pkg.sv ====
// Constants and types shared by the three-wire serial channel files
package tws_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_ADDR = 16'hFF90;
  localparam logic [15:0] SHIFT_ADDR = 16'hFF92;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_RX_BIT = 2;
  localparam int MODE_SEL_HI_BIT = 1;
  localparam int MODE_SEL_LO_BIT = 0;

  typedef struct packed {
    logic channel_enable;
    logic [3:0] reserved;
    logic transfer_mode_flag;
    logic clock_select_hi;
    logic clock_select_lo;
  } tws_mode_t;

  // ----------------------------------------------------------------
  // Clock select codes and divide ratios
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_EXTERNAL = 2'h0;
  localparam logic [1:0] SEL_DIV32 = 2'h1;
  localparam logic [1:0] SEL_DIV64 = 2'h2;
  localparam logic [1:0] SEL_DIV128 = 2'h3;
  localparam int DIV_32 = 32;
  localparam int DIV_64 = 64;
  localparam int DIV_128 = 128;
  localparam int DIV_CNT_W = 7;

  // ----------------------------------------------------------------
  // Word framing and buffering
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 8;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } tws_cpu_req_t;

endpackage : tws_pkg

// ==== src/tws_fifo.sv ====
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module tws_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Elaboration guard: pointer wrap needs a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
    $error("tws_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic push, pop;

  // ----------------------------------------------------------------
  // Pointer and count update
  // ----------------------------------------------------------------
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count_reg != (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (count_reg != '0) && !flush;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (flush) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
    end else begin
      if (push) begin
        wr_ptr_next = wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_next = rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_next = count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_next = count_reg - (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // Storage holds no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

endmodule : tws_fifo

// ==== src/tws_serial.sv ====
// Three-wire clocked serial channel with mode and shift registers
//
// Operation
// - Disabled halts shifting, clears counter, releases pins
// - Receive-only mode holds serial output low
// - Clock select: external, or divide 32/64/128
// - Transfers move whole eight-bit words
// - Output bit changes on falling serial clock
// - Input bit sampled on rising serial clock
// - After eight bits stop and set flag
// - Start needs enable and idle high clock
// - Write starts transfer in transmit mode
// - Read starts transfer in receive-only mode
// - Enabling after a write never starts transfer
// - Output and clock pins are open-drain
// - Enabling turns buffers on, lines wait
// - Disabling turns buffers off, pins become ports
`timescale 1ns/1ps
module tws_serial #(
  parameter int FIFO_WORDS = tws_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register access port
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_wr_ready,
  // Transfer completion
  input wire logic irq_clear,
  output logic transfer_done_irq_flag,
  // Serial input pin
  input wire logic serial_in_pin,
  // Serial output pin, open-drain
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  // Serial clock pin, open-drain
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe
);

  // Elaboration guard: queue and its mirror need 2..256, power of two
  if (FIFO_WORDS < 2 || FIFO_WORDS > 256
      || (FIFO_WORDS & (FIFO_WORDS - 1)) != 0) begin : g_bad_depth
    $error("tws_serial: FIFO_WORDS out of range");
  end

  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HIGH = 3'b010,
    ST_LOW = 3'b100
  } tws_state_t;

  tws_pkg::tws_cpu_req_t req;
  tws_pkg::tws_mode_t mode_reg, mode_next;
  tws_state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [tws_pkg::DIV_CNT_W-1:0] div_cnt_reg, div_cnt_next;
  logic sck_lvl_reg, sck_lvl_next;
  logic so_lvl_reg, so_lvl_next;
  logic rx_pend_reg, rx_pend_next;
  logic done_reg, done_next;
  logic [7:0] rdata_reg, rdata_next;
  logic so_oe_reg, sck_oe_reg;
  logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
  logic si_s1_reg, si_s2_reg;

  logic enabled, rx_only, int_clk;
  logic hit_mode, hit_shift;
  logic [tws_pkg::DIV_CNT_W-1:0] half_last;
  logic tick, fall_evt, rise_evt, start_ok;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_out_data;
  logic fifo_push, fifo_drain;
  logic [8:0] fill_reg, fill_next;
  logic wr_ready_reg, wr_ready_next;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  assign req = '{addr: cpu_addr, wr: cpu_wr, rd: cpu_rd, wdata: cpu_wdata};
  assign enabled = mode_reg.channel_enable;
  assign rx_only = mode_reg.transfer_mode_flag;
  assign int_clk = {mode_reg.clock_select_hi, mode_reg.clock_select_lo}
                   != tws_pkg::SEL_EXTERNAL;

  // Address decode for the two registers
  always_comb begin
    hit_mode = 1'b0;
    hit_shift = 1'b0;
    if (req.addr == tws_pkg::MODE_ADDR) begin
      hit_mode = 1'b1;
    end else if (req.addr == tws_pkg::SHIFT_ADDR) begin
      hit_shift = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Clock pin gets a third stage so edges come from settled samples
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sck_s1_reg <= 1'b1;
      sck_s2_reg <= 1'b1;
      sck_s3_reg <= 1'b1;
      si_s1_reg <= 1'b1;
      si_s2_reg <= 1'b1;
    end else begin
      sck_s1_reg <= serial_clock_pin_i;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      si_s1_reg <= serial_in_pin;
      si_s2_reg <= si_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Shift clock source
  // ----------------------------------------------------------------
  // Last count of the half period in core cycles (half period minus one) for the selected divide ratio
  always_comb begin
    case ({mode_reg.clock_select_hi, mode_reg.clock_select_lo})
      tws_pkg::SEL_DIV32: begin
        half_last = tws_pkg::DIV_CNT_W'(tws_pkg::DIV_32 / 2 - 1);
      end
      tws_pkg::SEL_DIV64: begin
        half_last = tws_pkg::DIV_CNT_W'(tws_pkg::DIV_64 / 2 - 1);
      end
      default: begin
        half_last = tws_pkg::DIV_CNT_W'(tws_pkg::DIV_128 / 2 - 1);
      end
    endcase
  end

  assign tick = (div_cnt_reg == half_last);

  // Edges seen by the engine: divider ticks or sampled pin edges
  always_comb begin
    if (int_clk) begin
      fall_evt = tick && sck_lvl_reg;
      rise_evt = tick && !sck_lvl_reg;
    end else begin
      fall_evt = sck_s3_reg && !sck_s2_reg;
      rise_evt = !sck_s3_reg && sck_s2_reg;
    end
  end

  // A new word waits for a stopped internal clock or a high line
  assign start_ok = enabled && (int_clk || sck_s2_reg);

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  // Only enabled transmit-mode writes queue; others load the register when disabled or when idle in receive-only
  assign fifo_in_valid = req.wr && hit_shift && enabled && !rx_only;
  assign fifo_pop = (state_reg == ST_IDLE) && start_ok && !rx_only;

  tws_fifo #(
    .WIDTH(tws_pkg::WORD_BITS),
    .DEPTH(FIFO_WORDS)
  ) u_tx_fifo (
    .clk(core_clk),
    .rst_b(rst_b),
    .flush(!enabled),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(req.wdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Write ready flag
  // ----------------------------------------------------------------
  // Occupancy mirror so the ready output leaves a flop, not gates
  assign fifo_push = fifo_in_valid && fifo_in_ready;
  assign fifo_drain = fifo_out_valid && fifo_pop;

  always_comb begin
    fill_next = fill_reg;
    if (!enabled) begin
      fill_next = '0;
    end else if (fifo_push && !fifo_drain) begin
      fill_next = fill_reg + 9'h001;
    end else if (fifo_drain && !fifo_push) begin
      fill_next = fill_reg - 9'h001;
    end
    wr_ready_next = mode_next.channel_enable
                    && (fill_next != 9'(FIFO_WORDS));
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fill_reg <= 9'h000;
      wr_ready_reg <= 1'b0;
    end else begin
      fill_reg <= fill_next;
      wr_ready_reg <= wr_ready_next;
    end
  end

  // ----------------------------------------------------------------
  // Mode register and read data
  // ----------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    rdata_next = rdata_reg;
    if (req.wr && hit_mode) begin
      mode_next = tws_pkg::tws_mode_t'(req.wdata);
      mode_next.reserved = 4'h0;
    end
    if (req.rd && hit_mode) begin
      rdata_next = mode_reg;
    end else if (req.rd && hit_shift) begin
      rdata_next = shift_reg;
    end else if (req.rd) begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_reg <= tws_pkg::tws_mode_t'(tws_pkg::MODE_RESET);
      rdata_reg <= 8'h00;
    end else begin
      mode_reg <= mode_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    div_cnt_next = tick ? '0 : div_cnt_reg + tws_pkg::DIV_CNT_W'(1);
    sck_lvl_next = sck_lvl_reg;
    so_lvl_next = so_lvl_reg;
    rx_pend_next = rx_pend_reg;
    done_next = done_reg;
    if (irq_clear) begin
      done_next = 1'b0;
    end
    // Receive start is armed by a read, consumed when the word begins
    if (req.rd && hit_shift && enabled && rx_only
        && state_reg == ST_IDLE) begin
      rx_pend_next = 1'b1;
    end
    if (!enabled) begin
      // Stopped: counter cleared, lines released, register plain
      state_next = ST_IDLE;
      bit_cnt_next = 3'h0;
      div_cnt_next = '0;
      sck_lvl_next = 1'b1;
      so_lvl_next = 1'b1;
      rx_pend_next = 1'b0;
      if (req.wr && hit_shift) begin
        shift_next = req.wdata;
      end
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Waiting state after enable: clock high, data keeps its level (pulled low in receive-only)
          sck_lvl_next = 1'b1;
          div_cnt_next = '0;
          bit_cnt_next = 3'h0;
          if (req.wr && hit_shift && rx_only) begin
            shift_next = req.wdata;
          end
          if (fifo_pop && fifo_out_valid) begin
            shift_next = fifo_out_data;
            state_next = ST_HIGH;
          end else if (rx_only && rx_pend_reg && start_ok) begin
            rx_pend_next = 1'b0;
            state_next = ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (fall_evt) begin
            so_lvl_next = shift_reg[7];
            sck_lvl_next = 1'b0;
            state_next = ST_LOW;
          end
        end
        ST_LOW: begin
          if (rise_evt) begin
            shift_next = {shift_reg[6:0], si_s2_reg};
            sck_lvl_next = 1'b1;
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'(tws_pkg::WORD_BITS - 1)) begin
              state_next = ST_IDLE;
              done_next = 1'b1;
            end else begin
              state_next = ST_HIGH;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // Pins are registered from next values so outputs are pure flops
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      shift_reg <= tws_pkg::SHIFT_RESET;
      bit_cnt_reg <= 3'h0;
      div_cnt_reg <= '0;
      sck_lvl_reg <= 1'b1;
      so_lvl_reg <= 1'b1;
      rx_pend_reg <= 1'b0;
      done_reg <= 1'b0;
      so_oe_reg <= 1'b0;
      sck_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      div_cnt_reg <= div_cnt_next;
      sck_lvl_reg <= sck_lvl_next;
      so_lvl_reg <= so_lvl_next;
      rx_pend_reg <= rx_pend_next;
      done_reg <= done_next;
      // Open-drain: only ever pull low, pull-up gives high
      so_oe_reg <= mode_next.channel_enable
                   && (mode_next.transfer_mode_flag || !so_lvl_next);
      sck_oe_reg <= mode_next.channel_enable && !sck_lvl_next
                    && ({mode_next.clock_select_hi,
                         mode_next.clock_select_lo}
                        != tws_pkg::SEL_EXTERNAL);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cpu_rdata = rdata_reg;
  assign cpu_wr_ready = wr_ready_reg;
  assign transfer_done_irq_flag = done_reg;
  assign serial_out_pin_oe = so_oe_reg;
  assign serial_clock_pin_oe = sck_oe_reg;
  assign serial_out_pin_o = 1'b0; // Open-drain drives low only
  assign serial_clock_pin_o = 1'b0;

endmodule : tws_serial

// ==== testbench/tws_serial_assertions.sv ====
// Port-level checker for the three-wire serial channel
`timescale 1ns/1ps
module tws_serial_checker #(
  parameter int FIFO_WORDS = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_wr_ready,
  // Completion
  input wire logic irq_clear,
  input wire logic transfer_done_irq_flag,
  // Pins
  input wire logic serial_in_pin,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe,
  input wire logic serial_clock_pin_i,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe
);
  // ----------
  // Helpers
  // ----------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] sh_reg, sh_next, hi_reg, hi_next, half;
  logic [3:0] rise_reg, rise_next;
  logic oe_reg, mwr;
  assign mwr = cpu_wr && cpu_addr == tws_pkg::MODE_ADDR;
  assign half = sh_reg[1:0] == 2'h1 ? 8'h10
              : sh_reg[1:0] == 2'h2 ? 8'h20 : 8'h40;
  // Mode shadow, low-phase length, falling clock count per word
  always_comb begin
    sh_next = mwr ? cpu_wdata : sh_reg;
    hi_next = serial_clock_pin_oe ? hi_reg + 8'h01 : 8'h00;
    rise_next = rise_reg;
    if (mwr || transfer_done_irq_flag) rise_next = 4'h0;
    else if (!oe_reg && serial_clock_pin_oe) rise_next = rise_reg + 4'h1;
  end
  // Counters restart with the device so stale counts never leak
  always_ff @(posedge core_clk) begin
    sh_reg <= rst_b ? sh_next : 8'h00;
    hi_reg <= rst_b ? hi_next : 8'h00;
    rise_reg <= rst_b ? rise_next : 4'h0;
    oe_reg <= rst_b ? serial_clock_pin_oe : 1'b0;
  end
  AST_SO_OPEN_DRAIN: assert property (serial_out_pin_o == 1'b0)
    else $error("serial out drives high");
  AST_SCK_OPEN_DRAIN: assert property (serial_clock_pin_o == 1'b0)
    else $error("serial clock drives high");
  AST_DISABLE_RELEASE: assert property (mwr && !cpu_wdata[7] |->
    ##[1:3] (!serial_clock_pin_oe && !serial_out_pin_oe))
    else $error("pins held after disable");
  AST_DISABLE_NO_QUEUE: assert property (mwr && !cpu_wdata[7] |=>
    !cpu_wr_ready) else $error("ready while disabled");
  AST_LOW_PHASE: assert property ($fell(serial_clock_pin_oe) && sh_reg[7]
    && sh_reg[1:0] != 2'h0 |-> hi_reg == half)
    else $error("clock low phase wrong");
  AST_EIGHT_BITS: assert property ($rose(transfer_done_irq_flag) &&
    sh_reg[1:0] != 2'h0 |-> rise_reg == 4'h8)
    else $error("word not eight clocks");
  AST_RX_SO_LOW: assert property (sh_reg[7] && sh_reg[2] && !mwr |=>
    serial_out_pin_oe) else $error("receive mode output not low");
  AST_EXT_NO_DRIVE: assert property (sh_reg[7] && sh_reg[1:0] == 2'h0
    && !mwr |=> !serial_clock_pin_oe) else $error("external clock driven");
  AST_IDLE_WAIT: assert property (mwr && cpu_wdata[7]
    && !sh_reg[7] |=> !serial_clock_pin_oe [*8])
    else $error("enable started a word");
  cover property ($rose(transfer_done_irq_flag) && sh_reg[2]);
  cover property ($rose(transfer_done_irq_flag) && sh_reg[1:0] == 2'h0);
  cover property ($fell(cpu_wr_ready) && sh_reg[7]);
endmodule : tws_serial_checker

bind tws_serial tws_serial_checker #(.FIFO_WORDS(FIFO_WORDS)) i_tws_chk (
  .core_clk(core_clk), .rst_b(rst_b), .cpu_addr(cpu_addr),
  .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
  .cpu_rdata(cpu_rdata), .cpu_wr_ready(cpu_wr_ready),
  .irq_clear(irq_clear), .transfer_done_irq_flag(transfer_done_irq_flag),
  .serial_in_pin(serial_in_pin), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_pin_oe(serial_out_pin_oe),
  .serial_clock_pin_i(serial_clock_pin_i),
  .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe(serial_clock_pin_oe));

// ==== testbench/tws_far_peer.sv ====
// Behavioural peripheral on the far side of the serial lines
`timescale 1ns/1ps
module tws_far_peer (
  // Wired lines
  input wire logic sck_line,
  input wire logic so_line,
  output logic si,
  output logic sck_drv,
  // Bench control
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic ext_go,
  output logic [7:0] rx_data
);
  logic [7:0] tx;
  initial begin
    si = 1'b1;
    sck_drv = 1'b0;
    tx = 8'h00;
    rx_data = 8'h00;
  end
  // Reply byte taken whole
  always @(posedge load) tx = load_data;
  // Bit out on falling clock, MSB first; refill keeps the line moving
  always @(negedge sck_line) begin
    si <= tx[7];
    tx <= {tx[6:0], ~tx[7]};
  end
  // Device output taken on the rising clock
  always @(posedge sck_line) rx_data <= {rx_data[6:0], so_line};
  // External clock: eight pulses, line left high between words
  always @(posedge ext_go) begin
    #13;
    repeat (8) begin
      sck_drv = 1'b1;
      #400;
      sck_drv = 1'b0;
      #400;
    end
  end
endmodule : tws_far_peer

// ==== testbench/tws_serial_tb.sv ====
// Self-checking bench for the three-wire serial channel
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tws_serial_tb;
  logic core_clk = 1'b0, rst_b = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0;
  logic irq_clear = 1'b0, p_ld = 1'b0, ext_go = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00, p_data = 8'h00, cpu_rdata, rx_data;
  logic flag, so_o, so_oe, sck_o, sck_oe, sck_drv, si, wr_ready;
  logic sck_line, so_line;
  int miscompares = 0, checked = 0, cycles = 0;
  logic [31:0] seed = 32'hDF25B85C;
  // Open-drain lines with pull-ups
  assign sck_line = ~(sck_oe | sck_drv);
  assign so_line = ~so_oe;
  tws_serial #(.FIFO_WORDS(8)) i_tws_serial (
    .core_clk(core_clk), .rst_b(rst_b), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .cpu_wr_ready(wr_ready), .irq_clear(irq_clear),
    .transfer_done_irq_flag(flag), .serial_in_pin(si),
    .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe),
    .serial_clock_pin_i(sck_line), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe(sck_oe));
  tws_far_peer i_tws_far_peer (
    .sck_line(sck_line), .so_line(so_line), .si(si), .sck_drv(sck_drv),
    .load(p_ld), .load_data(p_data), .ext_go(ext_go), .rx_data(rx_data));
  // ----------
  // Helpers
  // ----------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic [7:0] mode_of(input logic en, input logic rx,
                                         input logic [1:0] sel);
    return {en, 4'h0, rx, sel};
  endfunction : mode_of
  task automatic wrap_up();
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge core_clk);
    cpu_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge core_clk);
    cpu_rd <= 1'b0;
    @(posedge core_clk);
    d = cpu_rdata;
  endtask : rd
  // Bounded wait for the completion flag, then clear it
  task automatic wait_flag();
    for (int i = 0; i < 3000 && flag !== 1'b1; i++)
      @(posedge core_clk);
    `CHK(flag, 1'b1)
    irq_clear <= 1'b1;
    @(posedge core_clk);
    irq_clear <= 1'b0;
    @(posedge core_clk);
    `CHK(flag, 1'b0)
  endtask : wait_flag
  task automatic word(input logic [1:0] sel);
    logic [7:0] d, p, r;
    d = rnd();
    p = rnd();
    p_data <= p;
    p_ld <= 1'b1;
    wr(tws_pkg::MODE_ADDR, mode_of(1'b0, 1'b0, sel));
    p_ld <= 1'b0;
    wr(tws_pkg::MODE_ADDR, mode_of(1'b1, 1'b0, sel));
    wr(tws_pkg::SHIFT_ADDR, d);
    ext_go <= (sel == tws_pkg::SEL_EXTERNAL);
    wait_flag();
    ext_go <= 1'b0;
    `CHK(rx_data, d)
    rd(tws_pkg::SHIFT_ADDR, r);
    `CHK(r, p)
  endtask : word
  // Clock and hang guard
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    logic [7:0] r;
    logic [7:0] q [0:9];
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(tws_pkg::MODE_ADDR, r);
    `CHK(r, tws_pkg::MODE_RESET)
    rd(16'hFF91, r);
    `CHK(r, 8'h00)
    wr(tws_pkg::MODE_ADDR, 8'hF8);
    rd(tws_pkg::MODE_ADDR, r);
    `CHK(r, mode_of(1'b1, 1'b0, 2'h0))
    for (int s = 1; s < 4; s++)
      word(2'(s));
    word(tws_pkg::SEL_EXTERNAL);
    // Fill the queue past full, then drain in order
    wr(tws_pkg::MODE_ADDR, mode_of(1'b1, 1'b0, tws_pkg::SEL_DIV32));
    @(posedge core_clk);
    `CHK(wr_ready, 1'b1)
    for (int k = 0; k < 10; k++) begin
      q[k] = rnd();
      wr(tws_pkg::SHIFT_ADDR, q[k]);
    end
    @(posedge core_clk);
    `CHK(wr_ready, 1'b0)
    for (int k = 0; k < 9; k++) begin
      wait_flag();
      `CHK(rx_data, q[k])
    end
    `CHK(wr_ready, 1'b1)
    // Loaded while disabled, then enabled: nothing moves
    wr(tws_pkg::MODE_ADDR, mode_of(1'b0, 1'b0, tws_pkg::SEL_DIV32));
    wr(tws_pkg::SHIFT_ADDR, rnd());
    wr(tws_pkg::MODE_ADDR, mode_of(1'b1, 1'b0, tws_pkg::SEL_DIV32));
    repeat (300) @(posedge core_clk);
    `CHK(flag, 1'b0)
    `CHK(sck_oe, 1'b0)
    // Receive-only: read arms, then abort a word
    q[0] = rnd();
    p_data <= q[0];
    p_ld <= 1'b1;
    wr(tws_pkg::MODE_ADDR, mode_of(1'b1, 1'b1, tws_pkg::SEL_DIV64));
    p_ld <= 1'b0;
    rd(tws_pkg::SHIFT_ADDR, r);
    wait_flag();
    rd(tws_pkg::SHIFT_ADDR, r);
    `CHK(r, q[0])
    `CHK(so_oe, 1'b1)
    repeat (40) @(posedge core_clk);
    wr(tws_pkg::MODE_ADDR, mode_of(1'b0, 1'b1, tws_pkg::SEL_DIV64));
    repeat (3) @(posedge core_clk);
    `CHK(sck_oe, 1'b0)
    `CHK(so_oe, 1'b0)
    repeat (300) @(posedge core_clk);
    `CHK(flag, 1'b0)
    wrap_up();
  end
endmodule : tws_serial_tb
